// ===== design/nmc_core.sv
// nibble core: program counter, stack, datapath, serial and port control
`timescale 1ns/10ps
module nmc_core #(
  parameter int CYC_DIV    = nmc_pkg::CYC_DIV_DEF,
  parameter int FIFO_DEPTH = nmc_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic       MCLK,
  input  wire logic       RST,
  input  wire logic       HOST_BUS_MODE,
  output logic [9:0]      PROG_ADDR,
  input  wire logic [4:0] INSTR_CODE,
  input  wire logic [9:0] INSTR_ARG,
  output logic            CYCLE_SYNC,
  input  wire logic [3:0] GENERAL_INPUTS,
  input  wire logic       SERIAL_IN,
  output logic            SERIAL_OUT,
  output logic            SERIAL_CLOCK_OUTPUT,
  output logic [3:0]      DIGIT_OUT,
  output logic [3:0]      GPIO_OUT,
  input  wire logic [7:0] PORT_IN,
  output logic [7:0]      PORT_OUT,
  output logic            PORT_OE_N,
  output logic            HOST_FIFO_READY,
  output logic [3:0]      ACCUM,
  output logic            CARRY,
  output logic [3:0]      ENABLE_STATE
);
  localparam int PH_W = $clog2(CYC_DIV);
  localparam logic [PH_W-1:0] PH_EXEC = PH_W'(nmc_pkg::EXEC_PHASE);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(CYC_DIV - 1);
  localparam logic [PH_W-1:0] PH_HALF = PH_W'(CYC_DIV / 2);

  generate
    if (CYC_DIV < 8 || (CYC_DIV & (CYC_DIV - 1)) != 0)
      $error("CYC_DIV must be a power of two of at least 8");
  endgenerate

  typedef struct packed {
    logic [9:0]      program_counter;
    logic [9:0]      stack_level_one;
    logic [9:0]      stack_level_two;
    logic [9:0]      stack_level_three;
    logic [3:0]      a;
    logic            c;
    logic [1:0]      ram_row_select;
    logic [3:0]      ram_digit_select;
    logic [3:0]      d;
    logic [3:0]      g;
    logic [7:0]      q;
    logic [3:0]      en;
    logic [3:0]      serial_shift_counter;
    logic            clock_output_latch;
    logic [PH_W-1:0] phase;
    nmc_pkg::nmc_op_t op;
    logic [9:0]      arg;
    logic            si_s1;
    logic            si_s2;
    logic            si_s3;
    logic [3:0]      in_s1;
    logic [3:0]      in_s2;
    logic [3:0]      in_s3;
    logic            int_pend;
    logic            host_ready_flag;
    logic            so;
    logic            sk;
    logic            sync;
    logic [7:0]      port_out;
    logic            port_oe_n;
    logic [3:0]      gpio;
  } nmc_core_st_t;

  nmc_core_st_t st;
  nmc_core_st_t next_st;

  nmc_ram_if ram ();

  logic       fifo_push;
  logic       fifo_in_ready;
  logic       fifo_valid;
  logic       fifo_take;
  logic [7:0] fifo_data;

  nmc_ram u_ram (
    .MCLK   (MCLK),
    .RST    (RST),
    .port_m (ram.mem)
  );

  // host writes queue here so a busy core cannot lose a byte
  nmc_fifo #(
    .W (nmc_pkg::LATCH_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .MCLK      (MCLK),
    .RST       (RST),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (PORT_IN),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_data)
  );

  logic exec;
  logic si_fall;
  logic int_fall;
  logic wr_rise;
  logic rd_act;
  logic [4:0] sum;

  // decoded events from the synchronised copies only
  always_comb
  begin
    exec     = (st.phase == PH_EXEC);
    si_fall  = st.si_s3 && !st.si_s2;
    int_fall = st.in_s3[nmc_pkg::IN_RD] && !st.in_s2[nmc_pkg::IN_RD];
    wr_rise  = HOST_BUS_MODE && !st.in_s2[nmc_pkg::IN_CS]
               && st.in_s2[nmc_pkg::IN_WR]
               && !st.in_s3[nmc_pkg::IN_WR];
    rd_act   = HOST_BUS_MODE && !st.in_s2[nmc_pkg::IN_RD]
               && !st.in_s2[nmc_pkg::IN_CS];
    sum      = {1'b0, st.a} + {1'b0, ram.rdata} + {4'h0, st.c};
  end

  // data is taken at write release, where its setup is guaranteed
  assign fifo_push = wr_rise;
  // the drain stalls while an instruction writes the latch itself
  assign fifo_take = !(exec && nmc_pkg::loads_latch(st.op));

  // memory address: operand for direct ops, else the pointer
  assign ram.addr  = nmc_pkg::uses_direct(st.op)
                     ? st.arg[5:0]
                     : {st.ram_row_select, st.ram_digit_select};
  assign ram.we    = exec && (st.op == nmc_pkg::OP_XCHM
                     || st.op == nmc_pkg::OP_XCHD
                     || st.op == nmc_pkg::OP_STL);
  assign ram.wdata = (st.op == nmc_pkg::OP_STL)
                     ? (st.arg[0] ? PORT_IN[7:4] : PORT_IN[3:0])
                     : st.a;

  always_comb
  begin
    next_st = st;
    // two-flop synchronisers, first stage feeds only the second
    next_st.si_s1 = SERIAL_IN;
    next_st.si_s2 = st.si_s1;
    next_st.si_s3 = st.si_s2;
    next_st.in_s1 = GENERAL_INPUTS;
    next_st.in_s2 = st.in_s1;
    next_st.in_s3 = st.in_s2;
    next_st.phase = (st.phase == PH_LAST) ? '0 : st.phase + 1'b1;

    // a new falling edge wins over the clear at acknowledge
    if (st.phase == '0 && st.int_pend && st.en[nmc_pkg::EN_INT])
      next_st.int_pend = 1'b0;
    if (int_fall && st.en[nmc_pkg::EN_INT] && !HOST_BUS_MODE)
      next_st.int_pend = 1'b1;

    // counter mode: a serial exchange in the same clock wins
    if (st.en[nmc_pkg::EN_CNT] && si_fall)
      next_st.serial_shift_counter =
        st.serial_shift_counter - 4'h1;
    if (!st.en[nmc_pkg::EN_CNT] && st.phase == PH_LAST)
      next_st.serial_shift_counter =
        {st.serial_shift_counter[2:0], st.si_s2};

    // fetch at the cycle boundary, or take a pending interrupt
    if (st.phase == '0)
    begin
      if (st.int_pend && st.en[nmc_pkg::EN_INT])
      begin
        next_st.op                = nmc_pkg::OP_NOP;
        next_st.stack_level_one   = st.program_counter;
        next_st.stack_level_two   = st.stack_level_one;
        next_st.stack_level_three = st.stack_level_two;
        next_st.program_counter   = nmc_pkg::INT_VECTOR;
        next_st.en[nmc_pkg::EN_INT] = 1'b0;
      end
      else
      begin
        next_st.op  = nmc_pkg::nmc_op_t'(INSTR_CODE);
        next_st.arg = INSTR_ARG;
      end
    end

    // latch refill from the host queue when no instruction owns it
    if (fifo_valid && fifo_take)
      next_st.q = fifo_data;

    if (exec && st.op != nmc_pkg::OP_NOP)
    begin
      next_st.program_counter = st.program_counter + 10'h001;
      unique case (st.op)
        nmc_pkg::OP_ADDC:
        begin
          next_st.a = sum[3:0];
          next_st.c = sum[4];
        end
        nmc_pkg::OP_ADDI:
          next_st.a = st.a + st.arg[3:0];
        nmc_pkg::OP_LDM,
        nmc_pkg::OP_LDD,
        nmc_pkg::OP_XCHM,
        nmc_pkg::OP_XCHD:
          next_st.a = ram.rdata;
        nmc_pkg::OP_LDB:
          {next_st.ram_row_select, next_st.ram_digit_select} =
            st.arg[5:0];
        nmc_pkg::OP_CABD:
          next_st.ram_digit_select = st.a;
        nmc_pkg::OP_CABR:
          next_st.ram_row_select = st.a[1:0];
        nmc_pkg::OP_OBD:
          next_st.d = st.ram_digit_select;
        nmc_pkg::OP_XAS:
        begin
          next_st.a = st.serial_shift_counter;
          next_st.serial_shift_counter = st.a;
          next_st.clock_output_latch = st.c;
        end
        nmc_pkg::OP_LEI:
          next_st.en = st.arg[3:0];
        nmc_pkg::OP_LQMA:
          next_st.q = {ram.rdata, st.a};
        nmc_pkg::OP_LQPRG:
          next_st.q = st.arg[7:0];
        nmc_pkg::OP_RDQ:
          next_st.a = st.arg[0] ? st.q[7:4] : st.q[3:0];
        nmc_pkg::OP_RDL:
          next_st.a = st.arg[0] ? PORT_IN[7:4]
                                : PORT_IN[3:0];
        nmc_pkg::OP_STL:
          next_st.a = st.a;
        nmc_pkg::OP_OGI:
        begin
          next_st.g = st.arg[3:0];
          next_st.host_ready_flag = st.arg[0];
        end
        nmc_pkg::OP_JMP:
          next_st.program_counter = st.arg;
        nmc_pkg::OP_JP:
          next_st.program_counter =
            {st.program_counter[9:6], st.arg[5:0]};
        nmc_pkg::OP_CALL:
        begin
          next_st.stack_level_one   = st.program_counter + 10'h001;
          next_st.stack_level_two   = st.stack_level_one;
          next_st.stack_level_three = st.stack_level_two;
          next_st.program_counter   = st.arg;
        end
        nmc_pkg::OP_RET:
        begin
          next_st.program_counter = st.stack_level_one;
          next_st.stack_level_one = st.stack_level_two;
          next_st.stack_level_two = st.stack_level_three;
        end
        default:
          next_st.a = st.a;
      endcase
    end

    // a host write clears ready even against a program set
    if (wr_rise)
      next_st.host_ready_flag = 1'b0;

    // pin registers follow the next state so outputs are flops
    next_st.sync = (next_st.phase < PH_HALF);
    if (next_st.en[nmc_pkg::EN_CNT])
    begin
      next_st.so = next_st.en[nmc_pkg::EN_SOUT];
      next_st.sk = next_st.clock_output_latch;
    end
    else
    begin
      next_st.so = next_st.en[nmc_pkg::EN_SOUT]
                   && next_st.serial_shift_counter[3];
      next_st.sk = next_st.clock_output_latch && next_st.sync;
    end
    next_st.port_out = next_st.q;
    if (HOST_BUS_MODE)
      next_st.port_oe_n = !rd_act;
    else
      next_st.port_oe_n = !next_st.en[nmc_pkg::EN_LDRV];
    next_st.gpio = HOST_BUS_MODE
                   ? {next_st.g[3:1], next_st.host_ready_flag}
                   : next_st.g;
  end

  // reset clears core state; clock latch set so sk is sync
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      st                    <= '0;
      st.program_counter    <= nmc_pkg::PC_RESET;
      st.en                 <= nmc_pkg::EN_RESET;
      st.clock_output_latch <= nmc_pkg::SKL_RESET;
      st.op                 <= nmc_pkg::OP_NOP;
      st.port_oe_n          <= 1'b1;
      st.sync               <= 1'b1;
      st.sk                 <= nmc_pkg::SKL_RESET;
      // idle-high levels, so no false strobe edge follows reset
      {st.si_s1, st.si_s2, st.si_s3} <= 3'h7;
      {st.in_s1, st.in_s2, st.in_s3} <= 12'hfff;
    end
    else
      st <= next_st;
  end

  assign PROG_ADDR           = st.program_counter;
  assign CYCLE_SYNC          = st.sync;
  assign SERIAL_OUT          = st.so;
  assign SERIAL_CLOCK_OUTPUT = st.sk;
  assign DIGIT_OUT           = st.d;
  assign GPIO_OUT            = st.gpio;
  assign PORT_OUT            = st.port_out;
  assign PORT_OE_N           = st.port_oe_n;
  assign HOST_FIFO_READY     = fifo_in_ready;
  assign ACCUM               = st.a;
  assign CARRY               = st.c;
  assign ENABLE_STATE        = st.en;
endmodule : nmc_core

// ===== design/nmc_pkg.sv
// shared constants, opcodes and decode helpers of the nibble core
package nmc_pkg;

  // datapath widths
  localparam int PC_W    = 10;
  localparam int PAGE_W  = 6;
  localparam int NIB     = 4;
  localparam int RAM_AW  = 6;
  localparam int LATCH_W = 8;
  localparam int ARG_W   = 10;
  localparam int OP_W    = 5;

  // instruction cycle timing in master clocks, and default host fifo depth
  localparam int CYC_DIV_DEF    = 16;
  localparam int EXEC_PHASE     = 3;
  localparam int FIFO_DEPTH_DEF = 4;

  // reset and vector values
  localparam logic [9:0] PC_RESET   = 10'h000;
  localparam logic [9:0] INT_VECTOR = 10'h0ff;
  localparam logic [3:0] EN_RESET   = 4'h0;
  localparam logic       SKL_RESET  = 1'h1;

  // enable register bit positions
  localparam int EN_CNT  = 0;
  localparam int EN_INT  = 1;
  localparam int EN_LDRV = 2;
  localparam int EN_SOUT = 3;

  // general input positions, host strobes in host bus mode
  localparam int IN_RD = 1;
  localparam int IN_CS = 2;
  localparam int IN_WR = 3;

  typedef enum logic [4:0] {
    OP_NOP   = 5'h00, OP_ADDC  = 5'h01, OP_ADDI  = 5'h02,
    OP_LDM   = 5'h03, OP_XCHM  = 5'h04, OP_LDD   = 5'h05,
    OP_XCHD  = 5'h06, OP_LDB   = 5'h07, OP_CABD  = 5'h08,
    OP_CABR  = 5'h09, OP_OBD   = 5'h0a, OP_XAS   = 5'h0b,
    OP_LEI   = 5'h0c, OP_LQMA  = 5'h0d, OP_LQPRG = 5'h0e,
    OP_RDQ   = 5'h0f, OP_RDL   = 5'h10, OP_STL   = 5'h11,
    OP_OGI   = 5'h12, OP_JMP   = 5'h13, OP_JP    = 5'h14,
    OP_CALL  = 5'h15, OP_RET   = 5'h16
  } nmc_op_t;

  // direct-addressed memory instructions use the operand as address
  function automatic logic uses_direct(input nmc_op_t op);
    return (op == OP_LDD) || (op == OP_XCHD);
  endfunction : uses_direct

  // instructions that load the 8-bit latch themselves
  function automatic logic loads_latch(input nmc_op_t op);
    return (op == OP_LQMA) || (op == OP_LQPRG);
  endfunction : loads_latch

endpackage : nmc_pkg

// ===== design/nmc_ram_if.sv
// port bundle between the core and its data memory
`timescale 1ns/10ps
interface nmc_ram_if;
  logic [nmc_pkg::RAM_AW-1:0] addr;
  logic [nmc_pkg::NIB-1:0]    wdata;
  logic [nmc_pkg::NIB-1:0]    rdata;
  logic                       we;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem  (input addr, input wdata, input we, output rdata);
endinterface : nmc_ram_if

// ===== design/nmc_ram.sv
// 64 x 4 data memory with registered read data
`timescale 1ns/10ps
module nmc_ram (
  input  wire logic MCLK,
  input  wire logic RST,
  nmc_ram_if.mem    port_m
);
  localparam int DEPTH = 1 << nmc_pkg::RAM_AW;

  typedef struct packed {
    logic [DEPTH-1:0][nmc_pkg::NIB-1:0] cells;
    logic [nmc_pkg::NIB-1:0]            rdata;
  } nmc_ram_st_t;

  nmc_ram_st_t st;
  nmc_ram_st_t next_st;

  // cells are not cleared by reset; software clears them
  always_comb
  begin
    next_st       = st;
    next_st.rdata = st.cells[port_m.addr];
    if (port_m.we)
      next_st.cells[port_m.addr] = port_m.wdata;
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
      st.rdata <= '0;
    else
      st <= next_st;
  end

  assign port_m.rdata = st.rdata;
endmodule : nmc_ram

// ===== design/nmc_fifo.sv
// small valid/ready fifo with registered full and empty flags
`timescale 1ns/10ps
module nmc_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         MCLK,
  input  wire logic         RST,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  generate
    if (D < 2 || W < 1)
      $error("nmc_fifo needs D >= 2 and W >= 1");
  endgenerate

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
    logic                full;
    logic                empty;
    logic                rdy;
  } nmc_fifo_st_t;

  nmc_fifo_st_t st;
  nmc_fifo_st_t next_st;
  logic         push;
  logic         pop;

  // pointers wrap at D so any depth of 2 or more works, not only powers of two
  always_comb
  begin
    next_st = st;
    push    = in_valid && !st.full;
    pop     = !st.empty && out_ready;
    if (push)
    begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = (st.wp == AW'(D - 1)) ? '0 : st.wp + 1'b1;
    end
    if (pop)
      next_st.rp = (st.rp == AW'(D - 1)) ? '0 : st.rp + 1'b1;
    if (push && !pop)
      next_st.cnt = st.cnt + 1'b1;
    else if (pop && !push)
      next_st.cnt = st.cnt - 1'b1;
    next_st.full  = (next_st.cnt == CW'(D));
    next_st.empty = (next_st.cnt == '0);
    // ready kept as its own flop so the core's pin needs no gate
    next_st.rdy   = !next_st.full;
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      st       <= '0;
      st.empty <= 1'b1;
      st.rdy   <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign in_ready  = st.rdy;
  assign out_valid = !st.empty;
  assign out_data  = st.mem[st.rp];
endmodule : nmc_fifo

// ===== testbench/nmc_prog_rom.sv
// program memory model that answers each fetch address
`timescale 1ns/10ps
module nmc_prog_rom (
  input  wire logic       MCLK,
  input  wire logic [9:0] PROG_ADDR,
  output logic [4:0]      INSTR_CODE,
  output logic [9:0]      INSTR_ARG
);
  logic [14:0] mem [0:1023];

  // unwritten words read as no-op, so a stray fetch parks the core
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 15'h0000;
  end

  // one clock access, well inside the gap before the next fetch
  always_ff @(posedge MCLK)
  begin
    {INSTR_CODE, INSTR_ARG} <= mem[PROG_ADDR];
  end
endmodule : nmc_prog_rom

// ===== testbench/nmc_core_asserts.sv
// concurrent checks on the nibble core's top-level ports
`timescale 1ns/10ps
module nmc_core_asserts #(
  parameter int CYC_DIV = 16
) (
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic       HOST_BUS_MODE,
  input wire logic [9:0] PROG_ADDR,
  input wire logic       CYCLE_SYNC,
  input wire logic       SERIAL_OUT,
  input wire logic       SERIAL_CLOCK_OUTPUT,
  input wire logic [3:0] DIGIT_OUT,
  input wire logic       PORT_OE_N,
  input wire logic [3:0] ENABLE_STATE
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  // stable-enable guards skip the edge where a mode switch lands
  property p_reset_clear;
    $fell(RST) |-> PROG_ADDR == 10'h000 && ENABLE_STATE == 4'h0
      && SERIAL_CLOCK_OUTPUT && PORT_OE_N && !SERIAL_OUT;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("core not cleared by reset");

  property p_cycle_period;
    $rose(CYCLE_SYNC) |-> ##CYC_DIV $rose(CYCLE_SYNC);
  endproperty
  a_cycle_period: assert property (p_cycle_period)
    else $error("instruction cycle length wrong");

  property p_pc_settle;
    $changed(PROG_ADDR) |=> $stable(PROG_ADDR) [*2];
  endproperty
  a_pc_settle: assert property (p_pc_settle)
    else $error("program address moved twice in a cycle");

  property p_so_count;
    $stable(ENABLE_STATE) && ENABLE_STATE[0]
      |-> SERIAL_OUT == ENABLE_STATE[3];
  endproperty
  a_so_count: assert property (p_so_count)
    else $error("serial out differs from control bit in counter mode");

  property p_so_quiet;
    $stable(ENABLE_STATE) && !ENABLE_STATE[0] && !ENABLE_STATE[3]
      |-> !SERIAL_OUT;
  endproperty
  a_so_quiet: assert property (p_so_quiet)
    else $error("serial out not held low");

  property p_sk_sync;
    $stable(ENABLE_STATE) && !ENABLE_STATE[0]
      |-> !SERIAL_CLOCK_OUTPUT || CYCLE_SYNC;
  endproperty
  a_sk_sync: assert property (p_sk_sync)
    else $error("serial clock high outside sync in shift mode");

  property p_port_drive;
    !HOST_BUS_MODE && $stable(ENABLE_STATE)
      |-> PORT_OE_N == !ENABLE_STATE[2];
  endproperty
  a_port_drive: assert property (p_port_drive)
    else $error("port drive does not follow enable bit");

  property p_digit_with_pc;
    $changed(DIGIT_OUT) |-> $changed(PROG_ADDR);
  endproperty
  a_digit_with_pc: assert property (p_digit_with_pc)
    else $error("digit outputs changed without an instruction");

  property p_en_with_pc;
    $changed(ENABLE_STATE) |-> $changed(PROG_ADDR);
  endproperty
  a_en_with_pc: assert property (p_en_with_pc)
    else $error("enable register changed without an instruction");

  // main scenarios reached
  c_vector: cover property ($changed(PROG_ADDR) && PROG_ADDR == 10'h0ff);
  c_count_out: cover property (ENABLE_STATE[0] && SERIAL_OUT);
  c_sk_pulse: cover property (!ENABLE_STATE[0] && $fell(SERIAL_CLOCK_OUTPUT));
endmodule : nmc_core_asserts

// ===== testbench/nibble_mcu_core_io_control_bench.sv
// bench: program run, interrupt and host bus checks of the nibble core
`timescale 1ns/10ps
module nibble_mcu_core_io_control_bench;
  typedef struct packed
  {
    logic [9:0] pc;
    logic [3:0] acc;
    logic [3:0] en;
    logic [3:0] dig;
    logic       so;
  } nmc_note_t;

  logic       mclk = 1'b0;
  logic       rst, host, sync, sin, sout, sck, oe_n, fifo_rdy, carry;
  logic [9:0] prog_addr, iarg, last_pc;
  logic [4:0] icode;
  logic [3:0] gin, dig, gpio, acc, en;
  logic [7:0] pin, pout;
  logic       rand_on, mon_on;
  int         n_fail, cmp_count, seed;
  nmc_note_t  notes[$];
  nmc_note_t  exp_n;

  nmc_core nmc_core_inst (.MCLK(mclk), .RST(rst), .HOST_BUS_MODE(host),
    .PROG_ADDR(prog_addr), .INSTR_CODE(icode), .INSTR_ARG(iarg),
    .CYCLE_SYNC(sync), .GENERAL_INPUTS(gin), .SERIAL_IN(sin),
    .SERIAL_OUT(sout), .SERIAL_CLOCK_OUTPUT(sck), .DIGIT_OUT(dig),
    .GPIO_OUT(gpio), .PORT_IN(pin), .PORT_OUT(pout), .PORT_OE_N(oe_n),
    .HOST_FIFO_READY(fifo_rdy), .ACCUM(acc), .CARRY(carry),
    .ENABLE_STATE(en));
  nmc_prog_rom nmc_prog_rom_inst (.MCLK(mclk), .PROG_ADDR(prog_addr),
    .INSTR_CODE(icode), .INSTR_ARG(iarg));

  always #5 mclk = ~mclk;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic put(input logic [9:0] a, input nmc_pkg::nmc_op_t op,
                     input logic [9:0] arg);
    nmc_prog_rom_inst.mem[a] = {op, arg};
  endtask : put

  task automatic note(input logic [9:0] pc, input logic [3:0] a, e, d,
                      input logic s);
    notes.push_back('{pc, a, e, d, s});
  endtask : note

  // reset is held four cycles, then every cleared output except the port data is checked
  task automatic do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    check("reset", {prog_addr, acc, en, dig, gpio, sout, sck, oe_n, carry,
      sync, fifo_rdy}, {10'h000, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b1,
      1'b0, 1'b1, 1'b1});
  endtask : do_reset

  // random pin levels; port reads are level-only so any value is legal
  always @(posedge mclk)
  begin
    if (rand_on)
      pin <= $random(seed);
  end

  // every move of the program address retires the oldest note
  always @(posedge mclk)
  begin
    #1;
    if (mon_on && prog_addr !== last_pc)
    begin
      if (notes.size() == 0)
        check("extra fetch", prog_addr, last_pc);
      else
      begin
        exp_n = notes.pop_front();
        check("pc", prog_addr, exp_n.pc);
        check("state", {acc, en, dig, sout},
          {exp_n.acc, exp_n.en, exp_n.dig, exp_n.so});
      end
    end
    last_pc = prog_addr;
  end

  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish;
  end

  initial
  begin
    seed = 29651;
    n_fail = 0;
    cmp_count = 0;
    rst = 1'b1;
    host = 1'b0;
    gin = 4'hf;
    sin = 1'b1;
    pin = 8'h00;
    rand_on = 1'b1;
    mon_on = 1'b0;
    last_pc = 10'h000;
    #1;
    // let the model clear itself before loading the program
    put(10'h000, nmc_pkg::OP_LEI, 10'h001);
    put(10'h001, nmc_pkg::OP_LDB, 10'h025);
    put(10'h002, nmc_pkg::OP_OBD, 10'h000);
    put(10'h003, nmc_pkg::OP_ADDI, 10'h009);
    put(10'h004, nmc_pkg::OP_ADDI, 10'h009);
    put(10'h005, nmc_pkg::OP_LEI, 10'h00d);
    put(10'h006, nmc_pkg::OP_CALL, 10'h100);
    put(10'h100, nmc_pkg::OP_JP, 10'h005);
    // subroutine: latch round trip, then shifter exchanged out and back
    put(10'h105, nmc_pkg::OP_LQPRG, 10'h03c);
    put(10'h106, nmc_pkg::OP_RDQ, 10'h001);
    put(10'h107, nmc_pkg::OP_XAS, 10'h000);
    put(10'h108, nmc_pkg::OP_XAS, 10'h000);
    put(10'h109, nmc_pkg::OP_RET, 10'h000);
    put(10'h007, nmc_pkg::OP_LEI, 10'h002);
    put(10'h008, nmc_pkg::OP_JMP, 10'h008);
    note(10'h001, 4'h0, 4'h1, 4'h0, 1'b0);
    note(10'h002, 4'h0, 4'h1, 4'h0, 1'b0);
    note(10'h003, 4'h0, 4'h1, 4'h5, 1'b0);
    note(10'h004, 4'h9, 4'h1, 4'h5, 1'b0);
    note(10'h005, 4'h2, 4'h1, 4'h5, 1'b0);
    note(10'h006, 4'h2, 4'hd, 4'h5, 1'b1);
    note(10'h100, 4'h2, 4'hd, 4'h5, 1'b1);
    note(10'h105, 4'h2, 4'hd, 4'h5, 1'b1);
    note(10'h106, 4'h2, 4'hd, 4'h5, 1'b1);
    note(10'h107, 4'h3, 4'hd, 4'h5, 1'b1);
    note(10'h108, 4'h0, 4'hd, 4'h5, 1'b1);
    note(10'h109, 4'h3, 4'hd, 4'h5, 1'b1);
    note(10'h007, 4'h3, 4'hd, 4'h5, 1'b1);
    note(10'h008, 4'h3, 4'h2, 4'h5, 1'b0);
    note(10'h0ff, 4'h3, 4'h0, 4'h5, 1'b0);
    do_reset;
    mon_on = 1'b1;
    for (int i = 0; i < 400 && prog_addr !== 10'h008; i++)
      @(posedge mclk);
    repeat (20) @(posedge mclk);
    // low pulse of 2.5 instruction cycles on the interrupt input
    gin <= 4'hd;
    repeat (40) @(posedge mclk);
    gin <= 4'hf;
    repeat (40) @(posedge mclk);
    check("notes left", notes.size(), 0);
    // second reset into host bus mode: counter and port drive on, ready set
    mon_on = 1'b0;
    rand_on = 1'b0;
    put(10'h000, nmc_pkg::OP_LEI, 10'h005);
    put(10'h001, nmc_pkg::OP_OGI, 10'h001);
    put(10'h002, nmc_pkg::OP_XAS, 10'h000);
    put(10'h003, nmc_pkg::OP_JMP, 10'h003);
    host <= 1'b1;
    do_reset;
    repeat (20) @(posedge mclk);
    check("ready", gpio[0], 1'b1);
    // one counter pulse spans the host transfers, over two cycles long
    sin <= 1'b0;
    pin <= 8'ha5;
    gin <= 4'h3;
    repeat (4) @(posedge mclk);
    gin <= 4'hb;
    repeat (6) @(posedge mclk);
    gin <= 4'hf;
    pin <= 8'h5a;
    repeat (4) @(posedge mclk);
    check("ready after write", gpio[0], 1'b0);
    gin <= 4'h9;
    repeat (6) @(posedge mclk);
    check("read drive", oe_n, 1'b0);
    check("read data", pout, 8'ha5);
    gin <= 4'hf;
    repeat (6) @(posedge mclk);
    // enable bit 2 is set here, yet host mode keeps the port released
    check("bus released", oe_n, 1'b1);
    repeat (8) @(posedge mclk);
    sin <= 1'b1;
    // counter went 0 to f on the pulse and was exchanged into the acc
    check("count", acc, 4'hf);
    tally_and_finish;
  end
endmodule : nibble_mcu_core_io_control_bench

bind nmc_core nmc_core_asserts #(.CYC_DIV(CYC_DIV)) nmc_core_asserts_inst (
  .MCLK(MCLK), .RST(RST), .HOST_BUS_MODE(HOST_BUS_MODE),
  .PROG_ADDR(PROG_ADDR), .CYCLE_SYNC(CYCLE_SYNC), .SERIAL_OUT(SERIAL_OUT),
  .SERIAL_CLOCK_OUTPUT(SERIAL_CLOCK_OUTPUT), .DIGIT_OUT(DIGIT_OUT),
  .PORT_OE_N(PORT_OE_N), .ENABLE_STATE(ENABLE_STATE));
